// ---- rtl/vrec_pkg.sv ----
// Shared constants and types for both ends of the two-wire voice recorder port.
// Assumes a single 200 MHz core clock at each end.
package vrec_pkg;
    localparam int CLK_NS = 5;
    // Quarter of a bus clock period; the host builds the serial clock from four quarters.
    localparam int SCL_QTR_NS = 50;
    localparam int QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
    // Slave address default; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR_RST = 7'h2a;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BYTE_END = 4'h9;
    localparam logic DIR_WR = 1'b0;
    localparam logic DIR_RD = 1'b1;
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] W_SLA_WR = 3'h0;
    localparam logic [2:0] W_CMD = 3'h1;
    localparam logic [2:0] W_ADR_HI = 3'h2;
    localparam logic [2:0] W_ADR_LO = 3'h3;
    localparam logic [2:0] W_SLA_RD = 3'h4;
    typedef enum logic [1:0] {OP_WRITE = 2'h0, OP_STATUS = 2'h1, OP_ARRAY = 2'h2} op_t;
endpackage : vrec_pkg

// ---- rtl/vrec_if.sv ----
// Open-drain two-wire bus between the host end and the device end.
// Each driver only ever pulls low; the wire level is resolved here from the enables.
`timescale 1ns/100ps
interface vrec_if;
    logic host_scl_oe;
    logic host_scl_o;
    logic host_sda_oe;
    logic host_sda_o;
    logic dev_sda_oe;
    logic dev_sda_o;
    logic scl;
    logic sda;
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
    modport dev (input scl, input sda, output dev_sda_oe, output dev_sda_o);
    modport host (input scl, input sda, output host_scl_oe, output host_scl_o, output host_sda_oe,
        output host_sda_o);
endinterface : vrec_if

// ---- rtl/vrec_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/100ps
module vrec_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = vrec_pkg::FIFO_DEPTH
) (
    input wire logic clk, // core clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic in_valid, // write strobe
    output logic in_ready, // space left
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // data available
    input wire logic out_ready, // read strobe
    output logic [WIDTH-1:0] out_data // head entry
);
    import vrec_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic full;
    logic empty;
    assign empty = (wp_r == rp_r);
    assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp_r[AW-1:0]];
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_ready && !empty) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule : vrec_fifo

// ---- rtl/vrec_dev.sv ----
// Device end: slave of the two-wire port, taking command and address and returning data.
// Assumes RD_DATA shows the array byte at MEM_ADDR combinationally and STATUS is a held level.
`timescale 1ns/100ps
module vrec_dev #(
    parameter logic [6:0] SLAVE_ADDR = vrec_pkg::DEV_ADDR_RST
) (
    input wire logic CLK, // core clock
    input wire logic RST, // asynchronous reset, active high
    vrec_if.dev BUS, // two-wire bus
    output logic CMD_STB, // command and address complete
    output logic [7:0] CMD, // last command byte
    output logic [15:0] MEM_ADDR, // array pointer
    output logic WR_STB, // extra written byte taken
    output logic [7:0] WR_BYTE, // extra written byte
    output logic RD_STB, // array byte at MEM_ADDR taken
    input wire logic [7:0] RD_DATA, // array byte at MEM_ADDR
    input wire logic [7:0] STATUS // status byte
);
    import vrec_pkg::*;
    typedef enum logic [3:0] {D_IDLE = 4'b0001, D_ADDR = 4'b0010, D_RX = 4'b0100, D_TX = 4'b1000} dstate_t;
    dstate_t state_r;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    logic start_ev;
    logic stop_ev;
    logic rise;
    logic fall;
    logic [3:0] cnt_r;
    logic [7:0] rx_r;
    logic [7:0] tx_r;
    logic dir_r;
    logic mack_r;
    logic cmd_seen_r;
    logic [1:0] widx_r;
    logic pull_r;
    logic [7:0] load_byte;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], BUS.scl};
            sda_sy <= {sda_sy[0], BUS.sda};
            scl_d <= scl_sy[1];
            sda_d <= sda_sy[1];
        end
    end

    assign start_ev = scl_sy[1] && scl_d && sda_d && !sda_sy[1];
    assign stop_ev = scl_sy[1] && scl_d && !sda_d && sda_sy[1];
    assign rise = scl_sy[1] && !scl_d;
    assign fall = !scl_sy[1] && scl_d;
    // Without a command byte in this transfer a read returns status.
    assign load_byte = cmd_seen_r ? RD_DATA : STATUS;
    assign BUS.dev_sda_oe = pull_r;
    assign BUS.dev_sda_o = 1'b0;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= D_IDLE;
            cnt_r <= 4'h0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            dir_r <= DIR_WR;
            mack_r <= 1'b1;
            cmd_seen_r <= 1'b0;
            widx_r <= 2'h0;
            pull_r <= 1'b0;
            CMD_STB <= 1'b0;
            CMD <= 8'h00;
            MEM_ADDR <= 16'h0000;
            WR_STB <= 1'b0;
            WR_BYTE <= 8'h00;
            RD_STB <= 1'b0;
        end else begin
            CMD_STB <= 1'b0;
            WR_STB <= 1'b0;
            RD_STB <= 1'b0;
            if (stop_ev) begin
                state_r <= D_IDLE;
                pull_r <= 1'b0;
                cmd_seen_r <= 1'b0;
            end else if (start_ev) begin
                // A repeated start keeps the command seen earlier in the transfer.
                state_r <= D_ADDR;
                cnt_r <= 4'h0;
                pull_r <= 1'b0;
            end else if (state_r != D_IDLE && rise) begin
                if (cnt_r < ACK_SLOT) begin
                    rx_r <= {rx_r[6:0], sda_sy[1]};
                end else begin
                    mack_r <= sda_sy[1];
                end
                cnt_r <= cnt_r + 4'h1;
            end else if (state_r != D_IDLE && fall) begin
                if (cnt_r == ACK_SLOT) begin
                    case (state_r)
                        D_ADDR: begin
                            if (rx_r[7:1] == SLAVE_ADDR) begin
                                pull_r <= 1'b1;
                                dir_r <= rx_r[0];
                                widx_r <= 2'h0;
                            end else begin
                                state_r <= D_IDLE;
                            end
                        end
                        D_RX: begin
                            pull_r <= 1'b1;
                            case (widx_r)
                                2'h0: begin
                                    CMD <= rx_r;
                                    cmd_seen_r <= 1'b1;
                                end
                                2'h1: MEM_ADDR[15:8] <= rx_r;
                                2'h2: begin
                                    MEM_ADDR[7:0] <= rx_r;
                                    CMD_STB <= 1'b1;
                                end
                                default: begin
                                    WR_BYTE <= rx_r;
                                    WR_STB <= 1'b1;
                                end
                            endcase
                            if (widx_r != 2'h3) begin
                                widx_r <= widx_r + 2'h1;
                            end
                        end
                        default: pull_r <= 1'b0;
                    endcase
                end else if (cnt_r == BYTE_END) begin
                    cnt_r <= 4'h0;
                    if (state_r == D_TX && mack_r) begin
                        state_r <= D_IDLE;
                        pull_r <= 1'b0;
                    end else if (state_r == D_RX || dir_r == DIR_WR) begin
                        state_r <= D_RX;
                        pull_r <= 1'b0;
                    end else begin
                        state_r <= D_TX;
                        tx_r <= load_byte;
                        pull_r <= !load_byte[7];
                        if (cmd_seen_r) begin
                            RD_STB <= 1'b1;
                            MEM_ADDR <= MEM_ADDR + 16'h0001;
                        end
                    end
                end else if (state_r == D_TX) begin
                    tx_r <= {tx_r[6:0], 1'b0};
                    pull_r <= !tx_r[6];
                end
            end
        end
    end
endmodule : vrec_dev

// ---- rtl/vrec_host.sv ----
// Host end: bus master that writes command and address, reads status or array data.
// Assumes it is the only master; received bytes leave through an internal FIFO.
//
// How it works
// - data falling with clock high starts
// - data rising with clock high stops
// - one bit per pulse, stable while high
// - master starts only on an idle bus
// - eight data bits then acknowledge slot
// - any number of bytes per transfer
// - master clocks ack slot; transmitter releases
// - addressed receiving device acknowledges each byte
// - acknowledger holds data low whole high
// - master acks all but last byte
// - device releases data after master nack
// - first byte: seven address bits, direction
// - direction 0 writes, 1 reads
// - address byte first after every start
// - in writes device drives only acks
// - command write: address, command, two bytes
// - read without command returns status
// - array read: write address, then reverse
// - device sends while master acknowledges
`timescale 1ns/100ps
module vrec_host #(
    parameter logic [6:0] SLAVE_ADDR = vrec_pkg::DEV_ADDR_RST,
    parameter int DEPTH = vrec_pkg::FIFO_DEPTH
) (
    input wire logic CLK, // core clock
    input wire logic RST, // asynchronous reset, active high
    vrec_if.host BUS, // two-wire bus
    input wire logic REQ_VALID, // request offered
    output logic REQ_READY, // request taken when high with REQ_VALID
    input wire vrec_pkg::op_t REQ_OP, // transfer kind
    input wire logic [7:0] REQ_CMD, // command byte
    input wire logic [15:0] REQ_ADDR, // array address
    input wire logic [7:0] REQ_LEN, // bytes to read minus one
    output logic DONE, // transfer finished
    output logic NACK_ERR, // last transfer saw a device nack
    output logic RX_VALID, // read byte available
    input wire logic RX_READY, // read byte consumed
    output logic [7:0] RX_DATA // read byte
);
    import vrec_pkg::*;
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_START = 5'b00010,
        H_TXB = 5'b00100,
        H_RXB = 5'b01000,
        H_STOP = 5'b10000
    } hstate_t;
    localparam int QW = $clog2(QTR_CYC + 1);
    hstate_t state_r;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [QW-1:0] qcnt_r;
    logic tick;
    logic stall;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [2:0] widx_r;
    logic [7:0] left_r;
    op_t op_r;
    logic [7:0] cmd_r;
    logic [15:0] addr_r;
    logic ack_r;
    logic scl_low_r;
    logic sda_low_r;
    logic push;
    logic fifo_ready;
    logic [7:0] nxt_byte;

    function automatic logic [7:0] tx_pick(input logic [2:0] w, input logic [7:0] c, input logic [15:0] a);
        case (w)
            W_SLA_WR: tx_pick = {SLAVE_ADDR, DIR_WR};
            W_CMD: tx_pick = c;
            W_ADR_HI: tx_pick = a[15:8];
            W_ADR_LO: tx_pick = a[7:0];
            default: tx_pick = {SLAVE_ADDR, DIR_RD};
        endcase
    endfunction : tx_pick

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
        end else begin
            scl_sy <= {scl_sy[0], BUS.scl};
            sda_sy <= {sda_sy[0], BUS.sda};
        end
    end

    // A read byte only starts when the FIFO has room, so the push never overflows.
    assign stall = (state_r == H_RXB) && (bit_r == 4'h0) && (q_r == 2'h0) && !fifo_ready;
    assign tick = (qcnt_r == QW'(QTR_CYC - 1)) && !stall;
    assign push = tick && (state_r == H_RXB) && (q_r == 2'h3) && (bit_r == ACK_SLOT);
    assign REQ_READY = (state_r == H_IDLE) && scl_sy[1] && sda_sy[1];
    assign BUS.host_scl_oe = scl_low_r;
    assign BUS.host_scl_o = 1'b0;
    assign BUS.host_sda_oe = sda_low_r;
    assign BUS.host_sda_o = 1'b0;
    assign nxt_byte = tx_pick(widx_r + 3'h1, cmd_r, addr_r);

    // The serial clock is built from quarter-period enables of the core clock.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            qcnt_r <= '0;
        end else if (state_r == H_IDLE || stall || tick) begin
            qcnt_r <= '0;
        end else begin
            qcnt_r <= qcnt_r + 1'b1;
        end
    end

    vrec_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk(CLK),
        .rst(RST),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(sh_r),
        .out_valid(RX_VALID),
        .out_ready(RX_READY),
        .out_data(RX_DATA)
    );

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= H_IDLE;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            widx_r <= W_SLA_WR;
            left_r <= 8'h00;
            op_r <= OP_WRITE;
            cmd_r <= 8'h00;
            addr_r <= 16'h0000;
            ack_r <= 1'b0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            DONE <= 1'b0;
            NACK_ERR <= 1'b0;
        end else begin
            DONE <= 1'b0;
            if (state_r == H_IDLE) begin
                if (REQ_VALID && REQ_READY) begin
                    state_r <= H_START;
                    q_r <= 2'h0;
                    op_r <= REQ_OP;
                    cmd_r <= REQ_CMD;
                    addr_r <= REQ_ADDR;
                    left_r <= REQ_LEN;
                    NACK_ERR <= 1'b0;
                    // A status read sends the read address with no command byte.
                    widx_r <= (REQ_OP == OP_STATUS) ? W_SLA_RD : W_SLA_WR;
                end
            end else if (tick) begin
                q_r <= q_r + 2'h1;
                case (q_r)
                    2'h0: scl_low_r <= 1'b0;
                    2'h1: begin
                        if (state_r == H_START) begin
                            sda_low_r <= 1'b1;
                        end else if (state_r == H_STOP) begin
                            sda_low_r <= 1'b0;
                        end else if (bit_r == ACK_SLOT) begin
                            ack_r <= sda_sy[1];
                        end else begin
                            sh_r <= (state_r == H_RXB) ? {sh_r[6:0], sda_sy[1]} : sh_r;
                        end
                    end
                    2'h2: begin
                        if (state_r == H_STOP) begin
                            state_r <= H_IDLE;
                            q_r <= 2'h0;
                            DONE <= 1'b1;
                        end else begin
                            scl_low_r <= 1'b1;
                        end
                    end
                    default: begin
                        case (state_r)
                            H_START: begin
                                state_r <= H_TXB;
                                bit_r <= 4'h0;
                                sh_r <= tx_pick(widx_r, cmd_r, addr_r);
                                sda_low_r <= !tx_pick(widx_r, cmd_r, addr_r)[7];
                            end
                            H_TXB: begin
                                if (bit_r != ACK_SLOT) begin
                                    bit_r <= bit_r + 4'h1;
                                    sh_r <= {sh_r[6:0], 1'b0};
                                    // The ack slot leaves data released for the device.
                                    sda_low_r <= (bit_r == 4'h7) ? 1'b0 : !sh_r[6];
                                end else if (ack_r) begin
                                    NACK_ERR <= 1'b1;
                                    state_r <= H_STOP;
                                    sda_low_r <= 1'b1;
                                end else if (widx_r == W_SLA_RD) begin
                                    state_r <= H_RXB;
                                    bit_r <= 4'h0;
                                    sda_low_r <= 1'b0;
                                end else if (widx_r == W_ADR_LO) begin
                                    if (op_r == OP_ARRAY) begin
                                        state_r <= H_START;
                                        widx_r <= W_SLA_RD;
                                        sda_low_r <= 1'b0;
                                    end else begin
                                        state_r <= H_STOP;
                                        sda_low_r <= 1'b1;
                                    end
                                end else begin
                                    widx_r <= widx_r + 3'h1;
                                    bit_r <= 4'h0;
                                    sh_r <= nxt_byte;
                                    sda_low_r <= !nxt_byte[7];
                                end
                            end
                            H_RXB: begin
                                if (bit_r != ACK_SLOT) begin
                                    bit_r <= bit_r + 4'h1;
                                    // Ack every byte but the last, which gets a nack.
                                    sda_low_r <= (bit_r == 4'h7) && (left_r != 8'h00);
                                end else if (left_r == 8'h00) begin
                                    state_r <= H_STOP;
                                    sda_low_r <= 1'b1;
                                end else begin
                                    left_r <= left_r - 8'h01;
                                    bit_r <= 4'h0;
                                    sda_low_r <= 1'b0;
                                end
                            end
                            default: state_r <= H_IDLE;
                        endcase
                    end
                endcase
            end
        end
    end
endmodule : vrec_host

// ---- tb/vrec_props.sv ----
// Concurrent checks on the two-wire link between the host end and the device end.
// Assumes it sees the resolved wires and the pull enables sampled by the core clock.
`timescale 1ns/100ps
module vrec_props (
    input wire logic CLK, // core clock
    input wire logic RST, // asynchronous reset, active high
    input wire logic host_sda_oe, // host pulls data low
    input wire logic dev_sda_oe, // device pulls data low
    input wire logic scl, // resolved clock wire
    input wire logic sda // resolved data wire
);
    logic [3:0] bit_r;
    logic scl_q_r;
    logic sda_q_r;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl;
            sda_q_r <= sda;
        end
    end

    // Bit position within the byte: 1 to 8 data, 9 acknowledge; a start restarts the count.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bit_r <= 4'h0;
        end else if (scl && scl_q_r && sda_q_r && !sda) begin
            bit_r <= 4'h0;
        end else if (scl && !scl_q_r) begin
            bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
        end
    end

    AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    // The window is a little wider than the sync lag so that edge phase does not matter.
    AST_DEV_EDGE_LAG: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl) && $past(scl, 6))
        else $error("device data changed outside the clock low phase");
    AST_HOST_DATA_MID: assert property ($changed(host_sda_oe) && scl |-> $past(scl, 8))
        else $error("host data changed at a clock edge");
    AST_START_FROM_IDLE: assert property (scl && $past(scl) && $fell(sda) |-> $past(sda, 8))
        else $error("start without released data line");
    AST_STOP_IDLE: assert property (scl && $past(scl) && $rose(sda) |-> (scl && sda) [*8])
        else $error("bus not idle after stop");
    AST_BIT_STABLE: assert property (scl && $past(scl) && bit_r > 4'h1 |-> $stable(sda))
        else $error("data moved while clock high");
    AST_ACK_ONE_DRIVER: assert property (scl && bit_r == 4'h9 |-> !(host_sda_oe && dev_sda_oe))
        else $error("both ends drive the acknowledge slot");
    AST_NACK_RELEASE: assert property ($fell(scl) && bit_r == 4'h9 && $past(sda) |-> !dev_sda_oe [*8])
        else $error("device drives after a missing acknowledge");

    COV_STOP: cover property (scl && $past(scl) && $rose(sda));
    COV_DEV_PULL: cover property ($rose(dev_sda_oe));
    COV_NACK: cover property ($fell(scl) && bit_r == 4'h9 && $past(sda));
endmodule : vrec_props

// ---- tb/voice_recorder_i2c_slave_port_tb_top.sv ----
// Bench joining the host end and the device end across one link, with random commands.
// Assumes the package quarter period, so the three transfers take some 800 to 2600 cycles each.
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module voice_recorder_i2c_slave_port_tb_top;
    import vrec_pkg::*;
    logic CLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, RX_READY = 1'b0;
    logic REQ_READY, DONE, NACK_ERR, RX_VALID, CMD_STB, WR_STB, RD_STB;
    op_t REQ_OP = OP_WRITE;
    logic [7:0] REQ_CMD = 8'h00, REQ_LEN = 8'h00, RX_DATA, CMD, WR_BYTE, STATUS = 8'h00, RD_DATA;
    logic [15:0] REQ_ADDR = 16'h0000, MEM_ADDR, addr;
    logic [8:0] sh = 9'h000;
    logic [8:0] first_q[$];
    logic [7:0] cmd;
    int miscompares = 0, total_checks = 0, cycles = 0, nb = 100, cmd_n = 0, rd_n = 0, wr_n = 0;
    localparam logic [6:0] SLAVE_ADDR_EXP = DEV_ADDR_RST;

    vrec_if link();
    vrec_host u_vrec_host (.CLK(CLK), .RST(RST), .BUS(link), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
        .REQ_OP(REQ_OP), .REQ_CMD(REQ_CMD), .REQ_ADDR(REQ_ADDR), .REQ_LEN(REQ_LEN), .DONE(DONE),
        .NACK_ERR(NACK_ERR), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA));
    vrec_dev u_vrec_dev (.CLK(CLK), .RST(RST), .BUS(link), .CMD_STB(CMD_STB), .CMD(CMD), .MEM_ADDR(MEM_ADDR),
        .WR_STB(WR_STB), .WR_BYTE(WR_BYTE), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .STATUS(STATUS));
    vrec_props props_chk (.CLK(CLK), .RST(RST), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
        .scl(link.scl), .sda(link.sda));

    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5a;
    endfunction : mem_byte

    // The array model answers at once, as the device end expects.
    assign RD_DATA = mem_byte(MEM_ADDR);

    always #2.5 CLK = ~CLK;

    // Strobes are counted at the falling edge, where they have settled.
    always @(negedge CLK) begin
        cmd_n += (CMD_STB === 1'b1);
        rd_n += (RD_STB === 1'b1);
        wr_n += (WR_STB === 1'b1);
    end

    // Wire monitor: keeps the first byte and its acknowledge after every start.
    always @(negedge link.sda) if (link.scl === 1'b1) nb = 0;
    always @(posedge link.scl) begin
        sh = {sh[7:0], link.sda};
        nb++;
        if (nb == 9) first_q.push_back(sh);
    end

    // The ceiling leaves about half again the expected run time of some 5000 cycles.
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic run_req(input op_t op, input logic [7:0] c, input logic [15:0] a, input logic [7:0] n);
        @(negedge CLK);
        while (REQ_READY !== 1'b1) @(negedge CLK);
        REQ_VALID = 1'b1;
        REQ_OP = op;
        REQ_CMD = c;
        REQ_ADDR = a;
        REQ_LEN = n;
        @(negedge CLK);
        REQ_VALID = 1'b0;
        while (DONE !== 1'b1) @(negedge CLK);
    endtask : run_req

    task automatic drain(input logic [7:0] exp_q[$]);
        foreach (exp_q[i]) begin
            `CHK("rx valid", 1'b1, RX_VALID)
            `CHK("rx byte", exp_q[i], RX_DATA)
            RX_READY = 1'b1;
            @(negedge CLK);
        end
        RX_READY = 1'b0;
        `CHK("rx empty", 1'b0, RX_VALID)
    endtask : drain

    // The byte is popped once, so the compare and the report see the same value.
    task automatic chk_first(input logic dir);
        logic [8:0] got;
        got = (first_q.size() > 0) ? first_q.pop_front() : 9'h1ff;
        `CHK("address byte and ack", {SLAVE_ADDR_EXP, dir, 1'b0}, got)
    endtask : chk_first

    initial begin
        void'($urandom(49));
        repeat (16) @(negedge CLK);
        RST = 1'b0;
        // Low byte all ones, so the second byte must carry into the high byte.
        cmd = 8'($urandom);
        addr = {8'($urandom), 8'hff};
        run_req(OP_ARRAY, cmd, addr, 8'h01);
        `CHK("command", cmd, CMD)
        `CHK("command strobes", 1, cmd_n)
        `CHK("array strobes", 2, rd_n)
        `CHK("pointer", 16'(addr + 16'h0002), MEM_ADDR)
        `CHK("nack flag", 1'b0, NACK_ERR)
        chk_first(DIR_WR);
        chk_first(DIR_RD);
        drain('{mem_byte(addr), mem_byte(16'(addr + 16'h0001))});
        $display("test array_read done");
        STATUS = 8'($urandom);
        run_req(OP_STATUS, 8'h00, 16'h0000, 8'h00);
        `CHK("array strobes", 2, rd_n)
        `CHK("pointer", 16'(addr + 16'h0002), MEM_ADDR)
        `CHK("nack flag", 1'b0, NACK_ERR)
        chk_first(DIR_RD);
        drain('{STATUS});
        $display("test status_read done");
        cmd = 8'($urandom);
        addr = 16'($urandom);
        run_req(OP_WRITE, cmd, addr, 8'h00);
        `CHK("command", cmd, CMD)
        `CHK("pointer", addr, MEM_ADDR)
        `CHK("command strobes", 2, cmd_n)
        `CHK("array strobes", 2, rd_n)
        `CHK("extra byte strobes", 0, wr_n)
        `CHK("extra byte", 8'h00, WR_BYTE)
        `CHK("nack flag", 1'b0, NACK_ERR)
        `CHK("rx empty", 1'b0, RX_VALID)
        chk_first(DIR_WR);
        $display("test command_write done");
        wrap_up();
    end
endmodule : voice_recorder_i2c_slave_port_tb_top
